/* design/sync_serial_command_port.sv */
// device side clocked serial command port
`timescale 1ns/10ps
module sync_serial_command_port #(
    parameter int BUSY_CYCLES = sync_serial_pkg::BUSY_CYC
) (
    input  wire logic                        clk,
    input  wire logic                        rstn,
    input  wire logic                        port_select_n,
    input  wire logic                        serialClk,
    input  wire logic                        serialIn,
    output logic                             serialOut,
    output logic                             serialOutEn,
    output logic                             command_busy_n,
    output sync_serial_pkg::command_t        command,
    output logic                             commandValid,
    input  wire logic [7:0]                  stateValue,
    input  wire logic [7:0]                  errorValue
);
    // *****************************************
    // elaboration checks
    // *****************************************
    if (BUSY_CYCLES < 1) begin : g_badBusy
        $error("busy cycles must be at least one");
    end

    // *****************************************
    // pin synchronisers
    // *****************************************
    logic selLvl, selRise, selFall;
    logic sckLvl, sckRise, sckFall;
    logic siLvl;

    edge_sync uSel (
        .clk      (clk),
        .rstn     (rstn),
        .asyncIn  (port_select_n),
        .resetVal (1'b1),
        .level    (selLvl),
        .rise     (selRise),
        .fall     (selFall)
    );
    edge_sync uSck (
        .clk      (clk),
        .rstn     (rstn),
        .asyncIn  (serialClk),
        .resetVal (1'b1),
        .level    (sckLvl),
        .rise     (sckRise),
        .fall     (sckFall)
    );
    edge_sync uSi (
        .clk      (clk),
        .rstn     (rstn),
        .asyncIn  (serialIn),
        .resetVal (1'b1),
        .level    (siLvl),
        .rise     (),
        .fall     ()
    );

    // *****************************************
    // edge selection
    // *****************************************
    // sampleRising_q resets high so a select held low behaves rising
    logic sampleRising_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            sampleRising_q <= 1'b1;                       // see R06
        else if (selFall)
            sampleRising_q <= sckLvl;                     // see R04 see R05
    end

    // during the fall cycle itself the select is already low; ignore edges
    wire active     = ~selLvl & ~selFall;
    wire sampleEdge = active & (sampleRising_q ? sckRise : sckFall);
    wire driveEdge  = active & (sampleRising_q ? sckFall : sckRise);

    // *****************************************
    // receive shift and byte assembly
    // *****************************************
    logic [2:0]                bitCnt_q;
    logic [6:0]                shift_q;
    logic [1:0]                bytePos_q;
    sync_serial_pkg::command_t cmd_q;
    logic                      cmdValid_q;

    wire       lastBit  = sampleEdge & (bitCnt_q == 3'h7);  // see R02
    wire [7:0] newByte  = {shift_q, siLvl};                 // see R01
    wire       fullCmd  = lastBit &
                          (bytePos_q == 2'(sync_serial_pkg::MAX_BYTES - 1));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bitCnt_q <= 3'h0;
            shift_q  <= 7'h00;
        end else if (selLvl) begin
            bitCnt_q <= 3'h0;                             // see R07
            shift_q  <= 7'h00;
        end else if (sampleEdge) begin
            bitCnt_q <= bitCnt_q + 3'h1;
            shift_q  <= newByte[6:0];                     // see R01
        end
    end

    // byte tracking restarts at each select high; a fourth byte wraps
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            bytePos_q <= 2'h0;
        else if (selLvl || fullCmd)
            bytePos_q <= 2'h0;                            // see R12
        else if (lastBit)
            bytePos_q <= bytePos_q + 2'h1;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmd_q <= '0;
        end else if (lastBit) begin
            unique case (bytePos_q)
                2'h0:    cmd_q.byte0 <= newByte;
                2'h1:    cmd_q.byte1 <= newByte;
                default: cmd_q.byte2 <= newByte;
            endcase
            cmd_q.count <= bytePos_q + 2'h1;              // see R12
        end
    end

    // a byte must complete in this frame, else a bare select pulse would
    // hand on the previous command again
    logic gotByte_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            gotByte_q <= 1'b0;
        else if (selLvl)
            gotByte_q <= 1'b0;                            // see R07
        else if (lastBit)
            gotByte_q <= 1'b1;
    end

    // command is handed on when select rises after whole bytes
    wire cmdDone = selRise & gotByte_q & (bitCnt_q == 3'h0);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            cmdValid_q <= 1'b0;
        else
            cmdValid_q <= cmdDone;
    end
    assign command      = cmd_q;
    assign commandValid = cmdValid_q;

    // *****************************************
    // read request decode
    // *****************************************
    // the readable byte changes only on a read request, so a host that
    // skips the request reads a stale value
    wire isRdState = lastBit & (bytePos_q == 2'h0) &
                     (newByte == sync_serial_pkg::CMD_RD_STATE);
    wire isRdErr   = lastBit & (bytePos_q == 2'h0) &
                     (newByte == sync_serial_pkg::CMD_RD_ERROR);
    wire isRdVer   = lastBit & (bytePos_q == 2'h0) &
                     (newByte == sync_serial_pkg::CMD_RD_VER);
    // judged from the stored first byte, since lastBit is long gone by the
    // time select rises
    wire readCode  = (cmd_q.byte0 == sync_serial_pkg::CMD_RD_STATE) |
                     (cmd_q.byte0 == sync_serial_pkg::CMD_RD_ERROR) |
                     (cmd_q.byte0 == sync_serial_pkg::CMD_RD_VER);

    logic [7:0] readVal_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            readVal_q <= sync_serial_pkg::RESET_READ;
        else if (isRdState)
            readVal_q <= stateValue;                      // see R10
        else if (isRdErr)
            readVal_q <= errorValue;
        else if (isRdVer)
            readVal_q <= sync_serial_pkg::VERSION_ID;
    end

    // *****************************************
    // status shift out
    // *****************************************
    logic [7:0] outShift_q;
    logic       firstOut_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            outShift_q <= 8'h00;
            firstOut_q <= 1'b1;
        end else if (selLvl) begin
            outShift_q <= readVal_q;                      // see R07
            firstOut_q <= 1'b1;
        end else if (driveEdge) begin
            firstOut_q <= 1'b0;                           // see R03
            if (!firstOut_q)
                outShift_q <= {outShift_q[6:0], outShift_q[7]};
        end
    end

    logic soEn_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            soEn_q <= 1'b0;
        else
            soEn_q <= ~selLvl;                            // see R08
    end
    assign serialOut   = outShift_q[7];
    assign serialOutEn = soEn_q;

    // *****************************************
    // busy timer
    // *****************************************
    localparam int BW = $clog2(BUSY_CYCLES + 1);
    logic [BW-1:0] busyCnt_q;
    wire busyStart = cmdDone & ~readCode;                 // see R11
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            busyCnt_q <= '0;
        else if (busyStart)
            busyCnt_q <= BW'(BUSY_CYCLES);                // see R11
        else if (busyCnt_q != '0)
            busyCnt_q <= busyCnt_q - 1'b1;
    end

    logic busyN_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            busyN_q <= 1'b1;
        else
            busyN_q <= ~(busyStart | (busyCnt_q > BW'(1)));
    end
    assign command_busy_n = busyN_q;

endmodule : sync_serial_command_port

/* design/sync_serial_pkg.sv */
// constants and types shared by the clocked serial command port
// Operation
// R01: the host shifts command bits in msb first while select is low and the port captures each one on its sampling edge.
// R02: a command byte counts as complete and is decoded on the eighth sampling edge of that byte.
// R03: while select is low the port shifts status bits out on its output edge, timed by the host clock.
// R04: with the serial clock high at the select fall, input is sampled on rising edges and output changes on falling edges.
// R05: with the serial clock low at the select fall, input is sampled on falling edges and output changes on rising edges.
// R06: with select held low from reset and no fall seen, the port samples on rising edges and drives on falling edges.
// R07: raising select returns the port and its bit counter to the initial state.
// R08: the serial output is not driven while select is high.
// R09: the host keeps the serial clock free of spurious pulses, since an extra pulse misaligns the bit count until select rises.
// R10: the host issues the matching read request command before reading status, error or version, and only that command refreshes the value.
// R11: after an ordinary command the active low busy output is held low for about ten microseconds.
// R12: bytes within one select period are assembled into multi byte commands and byte tracking restarts when select rises.
package sync_serial_pkg;

    localparam int          BYTE_BITS  = 8;
    localparam int          MAX_BYTES  = 3;
    localparam int          CLK_MHZ    = 100;
    localparam int          BUSY_US    = 10;
    localparam int          BUSY_CYC   = BUSY_US * CLK_MHZ;

    localparam logic [7:0]  CMD_RD_STATE = 8'hb0;
    localparam logic [7:0]  CMD_RD_ERROR = 8'hb1;
    localparam logic [7:0]  CMD_RD_VER   = 8'hb2;
    localparam logic [7:0]  VERSION_ID   = 8'h5a; // arbitrary value
    localparam logic [7:0]  RESET_READ   = 8'h00;

    // one assembled command, low bytes unused for short commands
    typedef struct packed {
        logic [7:0] byte0;
        logic [7:0] byte1;
        logic [7:0] byte2;
        logic [1:0] count;
    } command_t;

endpackage : sync_serial_pkg

/* design/edge_sync.sv */
// two flop synchroniser with edge detection on the synchronised level
`timescale 1ns/10ps
module edge_sync (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic asyncIn,
    input  wire logic resetVal,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic       meta_q;
    logic       sync_q;
    logic       last_q;
    logic [2:0] warm_q;

    // meta_q feeds only sync_q
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            last_q <= 1'b1;
            warm_q <= 3'h0;
        end else begin
            meta_q <= asyncIn;
            sync_q <= meta_q;
            last_q <= sync_q;
            warm_q <= {warm_q[1:0], 1'b1};
        end
    end

    // until the chain holds real samples the level shows resetVal and no
    // edge is flagged, so a pin idling away from it gives no false edge
    wire ready = warm_q[2];
    assign level = ready ? sync_q : resetVal;
    assign rise  = ready & sync_q & ~last_q;
    assign fall  = ready & ~sync_q & last_q;
endmodule : edge_sync

/* dv/sync_serial_command_port_checker.sv */
// assertions on the ports of the serial command port
`timescale 1ns/10ps
module sync_serial_command_port_checker #(
    parameter int BUSY_CYCLES = sync_serial_pkg::BUSY_CYC
) (
    input wire logic                      clk,
    input wire logic                      rstn,
    input wire logic                      port_select_n,
    input wire logic                      serialClk,
    input wire logic                      serialIn,
    input wire logic                      serialOut,
    input wire logic                      serialOutEn,
    input wire logic                      command_busy_n,
    input wire sync_serial_pkg::command_t command,
    input wire logic                      commandValid,
    input wire logic [7:0]                stateValue,
    input wire logic [7:0]                errorValue
);
    // ****************************************
    // busy length counter and read decode
    // ****************************************
    int  lowCnt_q;
    wire isRead = command.byte0 inside {sync_serial_pkg::CMD_RD_STATE,
        sync_serial_pkg::CMD_RD_ERROR, sync_serial_pkg::CMD_RD_VER};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lowCnt_q <= 0;
        end else begin
            lowCnt_q <= command_busy_n ? 0 : lowCnt_q + 1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_out_released: assert property (port_select_n [*4] |-> !serialOutEn)
        else $error("output driven while select is high");
    a_valid_pulse: assert property (commandValid |=> !commandValid)
        else $error("command pulse longer than one cycle");
    a_valid_at_rise: assert property (commandValid |->
        port_select_n && $past(port_select_n, 2))
        else $error("command delivered while selected");
    a_valid_bytes: assert property (commandValid |-> command.count != 2'h0)
        else $error("command delivered with no bytes");
    a_busy_length: assert property ($rose(command_busy_n) |->
        lowCnt_q inside {[BUSY_CYCLES - 1:BUSY_CYCLES + 1]})
        else $error("busy low for a wrong span");
    a_busy_cause: assert property ($fell(command_busy_n) |->
        commandValid || $past(commandValid) || $past(commandValid, 2))
        else $error("busy fell without a command");
    a_read_no_busy: assert property (commandValid && isRead &&
        command_busy_n |=> command_busy_n [*3])
        else $error("busy raised by a read request");
    a_cmd_steady: assert property (port_select_n [*5] |=> $stable(command))
        else $error("command changed while deselected");
endmodule : sync_serial_command_port_checker

bind sync_serial_command_port sync_serial_command_port_checker #(
    .BUSY_CYCLES(BUSY_CYCLES)) i_chk (.clk(clk), .rstn(rstn),
    .port_select_n(port_select_n), .serialClk(serialClk),
    .serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn),
    .command_busy_n(command_busy_n), .command(command),
    .commandValid(commandValid), .stateValue(stateValue),
    .errorValue(errorValue));

/* dv/serial_host_model.sv */
// host side model driving the serial command port pins
`timescale 1ns/10ps
module serial_host_model (
    output logic      selectN,
    output logic      sck,
    output logic      sdi,
    input  wire logic sdo
);
    initial begin
        selectN = 1'b1;
        sck     = 1'b1;
        sdi     = 1'b0;
    end

    // ****************************************
    // one frame: idle is the clock level at the select fall
    // ****************************************
    task automatic xfer(input logic idle, input logic [23:0] d,
                        input int n, output logic [7:0] rd);
        rd = 8'h00;
        sck = idle;
        #203;
        selectN = 1'b0;
        #150;
        // clean pulses only, the port cannot recover a lost count
        for (int i = n - 1; i >= 0; i--) begin
            sck = ~idle;
            sdi = d[i];
            #62.5;
            sck = idle;
            rd = {rd[6:0], sdo};
            #62.5;
        end
        #100;
        selectN = 1'b1;
        // released line must not keep showing the last bit
        sdi = ~sdi;
    endtask : xfer
endmodule : serial_host_model

/* dv/sync_serial_command_port_tb.sv */
// self-checking bench for the serial command port
`timescale 1ns/10ps
module sync_serial_command_port_tb;
    localparam int             BUSY = 20;
    logic                      clk = 1'b0;
    logic                      rstn = 1'b0;
    logic                      selectN, sck, sdi, sdo, sdoEn, busyN, cmdValid;
    logic [7:0]                stateValue = 8'h3c;
    logic [7:0]                errorValue = 8'hc5;
    logic [7:0]                rd;
    sync_serial_pkg::command_t command;
    int                        bad_count = 0;
    int                        num_checks = 0;
    // no pull on the line: a released output shows the inverse
    wire                       sdoLine = sdoEn ? sdo : ~sdo;

    always #5 clk = ~clk;

    sync_serial_command_port #(.BUSY_CYCLES(BUSY)) i_dut (
        .clk(clk), .rstn(rstn), .port_select_n(selectN), .serialClk(sck),
        .serialIn(sdi), .serialOut(sdo), .serialOutEn(sdoEn),
        .command_busy_n(busyN), .command(command),
        .commandValid(cmdValid), .stateValue(stateValue),
        .errorValue(errorValue));
    serial_host_model i_host (.selectN(selectN), .sck(sck), .sdi(sdi),
        .sdo(sdoLine));

    // ****************************************
    // checking and scenarios
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_cmd(input logic expValid, input logic expBusy);
        logic valid;
        logic busy;
        valid = 1'b0;
        busy = 1'b0;
        repeat (BUSY + 20) begin
            @(negedge clk);
            valid |= (cmdValid === 1'b1);
            busy |= (busyN === 1'b0);
        end
        chk(valid, expValid);
        chk(busy, expBusy);
        chk(busyN, 1'b1);
    endtask : wait_cmd

    task automatic t_write;
        i_host.xfer(1'b1, 24'h000012, 8, rd);
        wait_cmd(1'b1, 1'b1);
        chk(command.byte0, 8'h12);
        chk(command.count, 2'h1);
        i_host.xfer(1'b0, 24'ha1b2c3, 24, rd);
        wait_cmd(1'b1, 1'b1);
        chk({command.byte0, command.byte1, command.byte2}, 24'ha1b2c3);
        chk(command.count, 2'h3);
    endtask : t_write

    task automatic t_partial;
        i_host.xfer(1'b0, 24'h000fff, 12, rd);
        wait_cmd(1'b0, 1'b0);
        i_host.xfer(1'b1, 24'h000000, 0, rd);
        wait_cmd(1'b0, 1'b0);
        i_host.xfer(1'b1, 24'h00005e, 8, rd);
        wait_cmd(1'b1, 1'b1);
        chk(command.byte0, 8'h5e);
    endtask : t_partial

    task automatic t_read;
        logic [7:0] code;
        logic [7:0] exp;
        for (int k = 0; k < 3; k++) begin
            code = sync_serial_pkg::CMD_RD_STATE + 8'(k);
            exp = (k == 0) ? stateValue : (k == 1) ? errorValue
                : sync_serial_pkg::VERSION_ID;
            i_host.xfer(k[0], {16'h0000, code}, 8, rd);
            wait_cmd(1'b1, 1'b0);
            @(posedge clk);
            stateValue <= ~stateValue;
            errorValue <= ~errorValue;
            i_host.xfer(k[0], 24'h000000, 8, rd);
            chk(rd, exp);
            wait_cmd(1'b1, 1'b1);
        end
    endtask : t_read

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (5) @(posedge clk);
        t_write();
        t_partial();
        t_read();
        results();
    end

    initial begin
        #200000;
        bad_count++;
        results();
    end
endmodule : sync_serial_command_port_tb
